// ==== core/eds_pkg.sv ====
package eds_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int THIRD_CYCLES = CLK_HZ / 3;
  localparam logic [5:0] INFL_MAX = 6'h28;
  localparam logic [5:0] DEFL_MAX = 6'h3C;
  localparam logic [4:0] JOGN_MAX = 5'h14;
  localparam logic [3:0] RUN_MAX = 4'h9;
  localparam logic [6:0] STOP_MAX = 7'h63;
  localparam logic [6:0] SPEC_MIN = 7'h03;
  localparam logic [6:0] SPEC_MAX = 7'h0A;
  localparam logic [6:0] ZERO7 = 7'h00;

  typedef enum logic [3:0] {
    EDS_IDLE = 4'h0,
    EDS_SLOW = 4'h1,
    EDS_INFL = 4'h2,
    EDS_DEFL = 4'h3,
    EDS_JOG_CW = 4'h4,
    EDS_JOG_S1 = 4'h5,
    EDS_JOG_CCW = 4'h6,
    EDS_JOG_S2 = 4'h7,
    EDS_TILT = 4'h8,
    EDS_DONE = 4'h9
  } eds_state_t;
endpackage

// ==== core/eds_tick.sv ====
`timescale 1ns/10ps
module eds_tick #(
  parameter int DIV = 125000000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  output logic tick
);
  logic [31:0] cnt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h00000000;
      tick <= 1'b0;
    end else if (clr) begin
      cnt_reg <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_reg == 32'(DIV - 1)) begin
      cnt_reg <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule

// ==== core/eds_sequencer.sv ====
`timescale 1ns/10ps
module eds_sequencer #(
  parameter int SEC_DIV = eds_pkg::SEC_CYCLES,
  parameter int THIRD_DIV = eds_pkg::THIRD_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic START,
  input wire logic BASKET_SLOW,
  input wire logic TILT_UP_DONE,
  input wire logic [5:0] RIB_INFLATE_TIME,
  input wire logic [5:0] RIB_DEFLATE_TIME,
  input wire logic [4:0] JOG_REVERSAL_COUNT,
  input wire logic [3:0] JOG_RUN_TIME,
  input wire logic [6:0] JOG_STOP_TIME,
  input wire logic JOG_BEFORE_TILT,
  output logic RIB_INFLATE,
  output logic MOTOR_CW,
  output logic MOTOR_CCW,
  output logic BRAKE_ON,
  output logic TILT_UP,
  output logic BUSY,
  output logic DONE,
  output logic SETTING_ERROR,
  output logic [3:0] DISCHARGE_PROGRAM_STEP
);
  import eds_pkg::*;

  eds_state_t state_reg, state_next;
  logic [6:0] timer_reg, timer_next;
  logic [5:0] jogs_reg, jogs_next;
  logic pass_reg, pass_next;
  logic special_reg;
  logic sec_tick, third_tick, unit_tick, phase_clr;
  logic settings_ok;

  function automatic logic is_jog(input eds_state_t s);
    return s == EDS_JOG_CW || s == EDS_JOG_S1 || s == EDS_JOG_CCW || s == EDS_JOG_S2;
  endfunction

  // restart the timebases on each phase change so periods are whole
  assign phase_clr = state_next != state_reg;

  eds_tick #(.DIV(SEC_DIV)) u_sec (
    .clk(SYS_CLK),
    .rst(RESET),
    .clr(phase_clr),
    .tick(sec_tick)
  );

  eds_tick #(.DIV(THIRD_DIV)) u_third (
    .clk(SYS_CLK),
    .rst(RESET),
    .clr(phase_clr),
    .tick(third_tick)
  );

  assign unit_tick = (is_jog(state_reg) && special_reg) ? third_tick : sec_tick;

  always_comb begin
    settings_ok = 1'b1;
    if (RIB_INFLATE_TIME > INFL_MAX || RIB_DEFLATE_TIME > DEFL_MAX) begin
      settings_ok = 1'b0;
    end
    if (JOG_REVERSAL_COUNT == 5'h00 || JOG_REVERSAL_COUNT > JOGN_MAX) begin
      settings_ok = 1'b0;
    end
    if (JOG_RUN_TIME > RUN_MAX) begin
      settings_ok = 1'b0;
    end
    if (JOG_RUN_TIME == 4'h0) begin
      if (JOG_STOP_TIME < SPEC_MIN || JOG_STOP_TIME > SPEC_MAX) begin
        settings_ok = 1'b0;
      end
    end else if (JOG_STOP_TIME == ZERO7 || JOG_STOP_TIME > STOP_MAX) begin
      settings_ok = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      special_reg <= 1'b0;
    end else if (state_reg == EDS_IDLE && START) begin
      special_reg <= JOG_RUN_TIME == 4'h0;
    end
  end

  // jog series count: reversals, or twice the stop setting in special mode
  function automatic logic [5:0] jog_total(input logic spec);
    return spec ? {JOG_STOP_TIME[4:0], 1'b0} : {1'b0, JOG_REVERSAL_COUNT};
  endfunction

  function automatic logic [6:0] run_len(input logic spec);
    return spec ? 7'h01 : {3'h0, JOG_RUN_TIME};
  endfunction

  function automatic logic [6:0] stop_len(input logic spec);
    return spec ? 7'h01 : JOG_STOP_TIME;
  endfunction

  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    jogs_next = jogs_reg;
    pass_next = pass_reg;
    if (unit_tick && timer_reg != ZERO7) begin
      timer_next = timer_reg - 7'h01;
    end
    unique case (state_reg)
      EDS_IDLE: begin
        if (START && settings_ok) begin
          state_next = EDS_SLOW;
          pass_next = 1'b0;
        end
      end
      EDS_SLOW: begin
        if (BASKET_SLOW) begin
          state_next = EDS_INFL;
          timer_next = {1'b0, RIB_INFLATE_TIME};
        end
      end
      EDS_INFL: begin
        if (timer_reg == ZERO7) begin
          if (JOG_BEFORE_TILT) begin
            state_next = EDS_DEFL;
            timer_next = {1'b0, RIB_DEFLATE_TIME};
          end else begin
            state_next = EDS_TILT;
          end
        end
      end
      EDS_TILT: begin
        if (TILT_UP_DONE) begin
          if (JOG_BEFORE_TILT) begin
            state_next = EDS_JOG_CW;
            timer_next = run_len(special_reg);
            jogs_next = jog_total(special_reg);
          end else begin
            state_next = EDS_DEFL;
            timer_next = {1'b0, RIB_DEFLATE_TIME};
          end
        end
      end
      EDS_DEFL: begin
        if (timer_reg == ZERO7) begin
          state_next = EDS_JOG_CW;
          timer_next = run_len(special_reg);
          jogs_next = jog_total(special_reg);
        end
      end
      EDS_JOG_CW: begin
        if (timer_reg == ZERO7) begin
          state_next = EDS_JOG_S1;
          timer_next = stop_len(special_reg);
        end
      end
      EDS_JOG_S1: begin
        if (timer_reg == ZERO7) begin
          state_next = EDS_JOG_CCW;
          timer_next = run_len(special_reg);
        end
      end
      EDS_JOG_CCW: begin
        if (timer_reg == ZERO7) begin
          state_next = EDS_JOG_S2;
          timer_next = stop_len(special_reg);
        end
      end
      EDS_JOG_S2: begin
        if (timer_reg == ZERO7) begin
          jogs_next = jogs_reg - 6'h01;
          if (jogs_reg > 6'h01) begin
            state_next = EDS_JOG_CW;
            timer_next = run_len(special_reg);
          end else if (JOG_BEFORE_TILT && !pass_reg) begin
            state_next = EDS_TILT;
            pass_next = 1'b1;
          end else begin
            state_next = EDS_DONE;
          end
        end
      end
      EDS_DONE: begin
        if (!START) begin
          state_next = EDS_IDLE;
        end
      end
      default: state_next = EDS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= EDS_IDLE;
      timer_reg <= ZERO7;
      jogs_reg <= 6'h00;
      pass_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      jogs_reg <= jogs_next;
      pass_reg <= pass_next;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      RIB_INFLATE <= 1'b0;
      MOTOR_CW <= 1'b0;
      MOTOR_CCW <= 1'b0;
      BRAKE_ON <= 1'b0;
      TILT_UP <= 1'b0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      SETTING_ERROR <= 1'b0;
      DISCHARGE_PROGRAM_STEP <= 4'h0;
    end else begin
      RIB_INFLATE <= state_next == EDS_INFL;
      MOTOR_CW <= state_next == EDS_JOG_CW;
      MOTOR_CCW <= state_next == EDS_JOG_CCW;
      BRAKE_ON <= is_jog(state_next) && special_reg;
      // basket stays up from the tilt until the run ends, never while idle
      TILT_UP <= state_next != EDS_IDLE && (state_next == EDS_TILT || pass_next
                 || (!JOG_BEFORE_TILT && state_next != EDS_SLOW && state_next != EDS_INFL));
      BUSY <= state_next != EDS_IDLE && state_next != EDS_DONE;
      DONE <= state_next == EDS_DONE;
      SETTING_ERROR <= state_reg == EDS_IDLE && START && !settings_ok;
      DISCHARGE_PROGRAM_STEP <= state_next;
    end
  end

  property p_infl_after_slow;
    @(posedge SYS_CLK) disable iff (RESET)
      (state_reg == EDS_SLOW && state_next == EDS_INFL) |-> BASKET_SLOW;
  endproperty
  a_infl_after_slow: assert property (p_infl_after_slow) else $error("inflation before basket slow");

  property p_zero_count_refused;
    @(posedge SYS_CLK) disable iff (RESET)
      (state_reg == EDS_IDLE && START && JOG_REVERSAL_COUNT == 5'h00) |=> (state_reg == EDS_IDLE && SETTING_ERROR);
  endproperty
  a_zero_count_refused: assert property (p_zero_count_refused) else $error("zero jog count accepted");

  sequence s_cw_end;
    state_reg == EDS_JOG_CW && timer_reg == ZERO7;
  endsequence
  property p_cw_then_stop;
    @(posedge SYS_CLK) disable iff (RESET) s_cw_end |=> state_reg == EDS_JOG_S1 ##1 !MOTOR_CW && !MOTOR_CCW;
  endproperty
  a_cw_then_stop: assert property (p_cw_then_stop) else $error("cw run not followed by stop");

  property p_brake_special;
    @(posedge SYS_CLK) disable iff (RESET) (MOTOR_CW || MOTOR_CCW) |-> (BRAKE_ON == special_reg);
  endproperty
  a_brake_special: assert property (p_brake_special) else $error("brake state wrong while jogging");

  property p_no_jog_before_defl;
    @(posedge SYS_CLK) disable iff (RESET)
      (state_reg == EDS_DEFL && timer_reg != ZERO7) |=> state_reg != EDS_JOG_CW;
  endproperty
  a_no_jog_before_defl: assert property (p_no_jog_before_defl) else $error("jog began during deflation");

  property p_defl_order;
    @(posedge SYS_CLK) disable iff (RESET)
      (state_reg == EDS_TILT && state_next == EDS_DEFL) |-> !JOG_BEFORE_TILT;
  endproperty
  a_defl_order: assert property (p_defl_order) else $error("deflation after tilt with flag set");

  property p_infl_hold;
    @(posedge SYS_CLK) disable iff (RESET)
      (state_reg == EDS_INFL && timer_reg != ZERO7) |=> state_reg == EDS_INFL;
  endproperty
  a_infl_hold: assert property (p_infl_hold) else $error("inflation ended early");

  property p_special_load;
    @(posedge SYS_CLK) disable iff (RESET)
      (state_reg == EDS_DEFL && timer_reg == ZERO7 && special_reg) |=> {2'b00, jogs_reg} == {$past(JOG_STOP_TIME), 1'b0};
  endproperty
  a_special_load: assert property (p_special_load) else $error("special jog count not doubled");

  property p_second_pass;
    @(posedge SYS_CLK) disable iff (RESET)
      (state_reg == EDS_JOG_S2 && timer_reg == ZERO7 && jogs_reg == 6'h01 && JOG_BEFORE_TILT && !pass_reg)
      |=> state_reg == EDS_TILT;
  endproperty
  a_second_pass: assert property (p_second_pass) else $error("jog series not repeated after tilt");

  property p_idle_quiet;
    @(posedge SYS_CLK) disable iff (RESET)
      state_reg == EDS_IDLE |-> !(TILT_UP || MOTOR_CW || MOTOR_CCW || RIB_INFLATE || BRAKE_ON);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("actuator active while idle");
endmodule

// ==== sim/eds_plant.sv ====
`timescale 1ns/10ps
module eds_plant #(
  parameter int SLOW_DLY = 5,
  parameter int TILT_DLY = 4
) (
  input wire logic clk,
  input wire logic busy,
  input wire logic tilt_up,
  output logic basket_slow,
  output logic tilt_done
);
  int slow_cnt = 0;
  int tilt_cnt = 0;
  initial begin
    basket_slow = 1'b0;
    tilt_done = 1'b0;
  end
  // basket coasts down for a while before the sensor reports slow
  always @(negedge clk) begin
    slow_cnt = busy ? slow_cnt + 1 : 0;
    tilt_cnt = tilt_up ? tilt_cnt + 1 : 0;
    basket_slow <= busy && slow_cnt > SLOW_DLY;
    tilt_done <= tilt_up && tilt_cnt > TILT_DLY;
  end
endmodule

// ==== sim/eds_testbench.sv ====
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; \
  if ((got) !== (ex)) begin fails++; $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  import eds_pkg::*;
  localparam int SD = 10;
  localparam int TD = 3;
  logic SYS_CLK, RESET, START, BASKET_SLOW, TILT_UP_DONE, JOG_BEFORE_TILT;
  logic [5:0] RIB_INFLATE_TIME, RIB_DEFLATE_TIME;
  logic [4:0] JOG_REVERSAL_COUNT;
  logic [3:0] JOG_RUN_TIME;
  logic [6:0] JOG_STOP_TIME;
  logic RIB_INFLATE, MOTOR_CW, MOTOR_CCW, BRAKE_ON, TILT_UP, BUSY, DONE, SETTING_ERROR;
  logic [3:0] DISCHARGE_PROGRAM_STEP;
  logic [3:0] cur_step = 4'h0;
  logic special = 1'b0;
  logic tilted = 1'b0;
  int fails = 0;
  int check_count = 0;
  int viol = 0;
  int cur_len = 0;
  logic [3:0] seen_q[$];
  int len_q[$];
  int ex_q[$];
  int el_q[$];

  eds_sequencer #(.SEC_DIV(SD), .THIRD_DIV(TD)) uut (.SYS_CLK(SYS_CLK), .RESET(RESET), .START(START),
    .BASKET_SLOW(BASKET_SLOW), .TILT_UP_DONE(TILT_UP_DONE), .RIB_INFLATE_TIME(RIB_INFLATE_TIME),
    .RIB_DEFLATE_TIME(RIB_DEFLATE_TIME), .JOG_REVERSAL_COUNT(JOG_REVERSAL_COUNT), .JOG_RUN_TIME(JOG_RUN_TIME),
    .JOG_STOP_TIME(JOG_STOP_TIME), .JOG_BEFORE_TILT(JOG_BEFORE_TILT), .RIB_INFLATE(RIB_INFLATE),
    .MOTOR_CW(MOTOR_CW), .MOTOR_CCW(MOTOR_CCW), .BRAKE_ON(BRAKE_ON), .TILT_UP(TILT_UP), .BUSY(BUSY),
    .DONE(DONE), .SETTING_ERROR(SETTING_ERROR), .DISCHARGE_PROGRAM_STEP(DISCHARGE_PROGRAM_STEP));
  eds_plant plant (.clk(SYS_CLK), .busy(BUSY), .tilt_up(TILT_UP), .basket_slow(BASKET_SLOW),
    .tilt_done(TILT_UP_DONE));

  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  // records each phase other than idle with its length and flags actuators outside their phase
  always @(negedge SYS_CLK) begin
    if (DISCHARGE_PROGRAM_STEP !== cur_step) begin
      if (cur_step != 4'h0) begin
        seen_q.push_back(cur_step);
        len_q.push_back(cur_len);
      end
      cur_step = DISCHARGE_PROGRAM_STEP;
      cur_len = 0;
      if (cur_step == 4'h8)
        tilted = 1'b1;
      else if (cur_step == 4'h0 || cur_step == 4'h1)
        tilted = 1'b0;
    end
    cur_len++;
    if (RIB_INFLATE !== (cur_step == 4'h2) || MOTOR_CW !== (cur_step == 4'h4) || MOTOR_CCW !== (cur_step == 4'h6)
        || (cur_step == 4'h2 && BASKET_SLOW !== 1'b1) || (cur_step == 4'h8 && TILT_UP !== 1'b1)
        || BRAKE_ON !== (special && cur_step >= 4'h4 && cur_step <= 4'h7) || TILT_UP !== tilted
        || BUSY !== (cur_step != 4'h0 && cur_step != 4'h9) || DONE !== (cur_step == 4'h9)
        || SETTING_ERROR !== 1'b0)
      viol++;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cfg(input logic a, input logic [5:0] i, input logic [5:0] d, input logic [4:0] c,
                     input logic [3:0] r, input logic [6:0] s);
    @(negedge SYS_CLK);
    JOG_BEFORE_TILT = a;
    RIB_INFLATE_TIME = i;
    RIB_DEFLATE_TIME = d;
    JOG_REVERSAL_COUNT = c;
    JOG_RUN_TIME = r;
    JOG_STOP_TIME = s;
  endtask

  task automatic refuse(input logic a, input logic [5:0] i, input logic [5:0] d, input logic [4:0] c,
                        input logic [3:0] r, input logic [6:0] s);
    cfg(a, i, d, c, r, s);
    START = 1'b1;
    @(negedge SYS_CLK);
    START = 1'b0;
    `CHK("setting_error", 1'b1, SETTING_ERROR)
    @(negedge SYS_CLK);
    `CHK("idle_step", 4'h0, DISCHARGE_PROGRAM_STEP)
    `CHK("idle_busy", 1'b0, BUSY)
  endtask

  task automatic add(input int st, input int ln);
    ex_q.push_back(st);
    el_q.push_back(ln == 0 ? 1 : ln);
  endtask

  task automatic jogs(input int n, input int r, input int s);
    for (int j = 0; j < n; j++) begin
      add(4, special ? TD : r * SD);
      add(5, special ? TD : s * SD);
      add(6, special ? TD : r * SD);
      add(7, special ? TD : s * SD);
    end
  endtask

  task automatic run(input logic a, input logic [5:0] i, input logic [5:0] d, input logic [4:0] c,
                     input logic [3:0] r, input logic [6:0] s);
    int n;
    int k;
    cfg(a, i, d, c, r, s);
    special = (r == 4'h0);
    n = special ? 2 * int'(s) : int'(c);
    seen_q.delete();
    len_q.delete();
    ex_q.delete();
    el_q.delete();
    viol = 0;
    START = 1'b1;
    for (k = 0; k < 20000 && DONE !== 1'b1; k++)
      @(negedge SYS_CLK);
    `CHK("done", 1'b1, DONE)
    START = 1'b0;
    for (k = 0; k < 10 && DISCHARGE_PROGRAM_STEP !== 4'h0; k++)
      @(negedge SYS_CLK);
    @(negedge SYS_CLK);
    add(1, -1);
    add(2, i * SD);
    if (!a)
      add(8, -1);
    add(3, d * SD);
    jogs(n, r, s);
    if (a) begin
      add(8, -1);
      jogs(n, r, s);
    end
    add(9, -1);
    `CHK("phase_count", ex_q.size(), seen_q.size())
    foreach (ex_q[m]) begin
      if (m < seen_q.size()) begin
        `CHK("step", ex_q[m], seen_q[m])
        if (el_q[m] > 0)
          `CHK("phase_len", 1'b1, len_q[m] - el_q[m] inside {[-1:2]})
      end
    end
    `CHK("actuators", 0, viol)
  endtask

  initial begin
    #400000;
    fails++;
    print_verdict();
  end

  initial begin
    RESET = 1'b1;
    START = 1'b0;
    JOG_BEFORE_TILT = 1'b0;
    RIB_INFLATE_TIME = 6'h00;
    RIB_DEFLATE_TIME = 6'h00;
    JOG_REVERSAL_COUNT = 5'h01;
    JOG_RUN_TIME = 4'h1;
    JOG_STOP_TIME = 7'h01;
    repeat (5) @(negedge SYS_CLK);
    RESET = 1'b0;
    `CHK("reset_outputs", 12'h000, {RIB_INFLATE, MOTOR_CW, MOTOR_CCW, BRAKE_ON, TILT_UP, BUSY, DONE,
      SETTING_ERROR, DISCHARGE_PROGRAM_STEP})
    refuse(1'b0, 6'h29, 6'h01, 5'h01, 4'h1, 7'h01);
    refuse(1'b0, 6'h01, 6'h3D, 5'h01, 4'h1, 7'h01);
    refuse(1'b0, 6'h01, 6'h01, 5'h00, 4'h1, 7'h01);
    refuse(1'b0, 6'h01, 6'h01, 5'h15, 4'h1, 7'h01);
    refuse(1'b0, 6'h01, 6'h01, 5'h01, 4'hA, 7'h01);
    refuse(1'b0, 6'h01, 6'h01, 5'h01, 4'h1, 7'h00);
    refuse(1'b0, 6'h01, 6'h01, 5'h01, 4'h1, 7'h64);
    refuse(1'b0, 6'h01, 6'h01, 5'h01, 4'h0, 7'h02);
    refuse(1'b0, 6'h01, 6'h01, 5'h01, 4'h0, 7'h0B);
    run(1'b0, 6'h02, 6'h01, 5'h02, 4'h1, 7'h02);
    run(1'b1, 6'h00, 6'h00, 5'h01, 4'h2, 7'h01);
    run(1'b0, 6'h01, 6'h01, 5'h14, 4'h0, 7'h0A);
    run(1'b1, 6'h01, 6'h01, 5'h01, 4'h0, 7'h03);
    run(1'b1, 6'h28, 6'h3C, 5'h01, 4'h9, 7'h63);
    print_verdict();
  end
endmodule
